// >>> oagen_pkg.sv
// constants, field layouts and mode types for the operand address generator
// Functional notes
// [RULE1] first source of a three-operand instruction is always a working register, direct
// [RULE2] second operand: register, data memory or 5-bit literal; result to register or memory
// [RULE3] general instructions offer 5-bit and 10-bit literal operands
// [RULE4] file register direct takes the address straight from the instruction field
// [RULE5] register direct reads or writes the working register, no memory access
// [RULE6] register indirect uses the pointer register unchanged as effective address
// [RULE7] post-modified: pointer is the address, then pointer steps by a constant
// [RULE8] pre-modified: pointer steps by a signed constant first, new value is address
// [RULE9] register offset: address is pointer plus offset register
// [RULE10] literal offset: address is pointer plus instruction literal
// [RULE11] move class adds indexed and literal offset modes, 8-bit and 16-bit literals
// [RULE12] move source and destination share one 4-bit offset register field
// [RULE13] dual-source dsp prefetch pointers must be working registers 8 to 11
// [RULE14] registers 8 and 9 prefetch through X, 10 and 11 through Y
// [RULE15] circular length is never stored; it follows from start and end addresses
// [RULE16] circular buffers may span up to 32K words
// [RULE17] X select value 15 disables modulo for X read and write generators
// [RULE18] X select is control bits 3:0; X modulo needs select not 15 and bit 15
// [RULE19] Y select is control bits 7:4; Y modulo needs select not 15 and bit 14
// [RULE20] modulo update past end wraps to start, below start wraps to end
// [RULE21] offset and pointer fields index sixteen registers; one cycle per calculation
package oagen_pkg;
    localparam int          APB_AW       = 8;
    localparam int          DW           = 16;
    localparam int          NUM_DEFAULT_WORKING_REGISTER     = 16;
    localparam int          SEL_W        = 4;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_XSTART   = 8'h04;
    localparam logic [7:0]  OFS_XEND     = 8'h08;
    localparam logic [7:0]  OFS_YSTART   = 8'h0c;
    localparam logic [7:0]  OFS_YEND     = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam logic [15:0] CTRL_RST     = 16'h00ff;
    localparam logic [15:0] START_RST    = 16'h0000;
    localparam logic [15:0] END_RST      = 16'hffff;
    localparam int          XSEL_LSB     = 0;
    localparam int          XSEL_MSB     = 3;
    localparam int          YSEL_LSB     = 4;
    localparam int          YSEL_MSB     = 7;
    localparam int          YEN_BIT      = 14;
    localparam int          XEN_BIT      = 15;
    localparam logic [3:0]  SEL_OFF      = 4'hf;
    localparam logic [3:0]  PF_X0        = 4'h8;
    localparam logic [3:0]  PF_X1        = 4'h9;
    localparam logic [3:0]  PF_Y0        = 4'ha;
    localparam logic [3:0]  PF_Y1        = 4'hb;
    localparam logic [15:0] LIT5_MASK    = 16'h001f;
    localparam logic [15:0] LIT10_MASK   = 16'h03ff;
    localparam logic [15:0] LIT8_MASK    = 16'h00ff;
    localparam logic [15:0] LIT16_MASK   = 16'hffff;

    typedef enum logic [2:0] {
        OAG_FILE_DIRECT,
        OAG_REG_DIRECT,
        OAG_IND,
        OAG_IND_POST,
        OAG_IND_PRE,
        OAG_IND_REGOFS,
        OAG_IND_LITOFS,
        OAG_LITERAL
    } oagen_mode_e;

    typedef enum logic {
        OAG_CLASS_MCU,
        OAG_CLASS_MOVE
    } oagen_class_e;
endpackage

// >>> oagen_top.sv
// operand effective-address generator with working registers and APB control registers
//
// The register offsets and the APB register port are this design's own decisions.
module oagen_top (
    input  wire logic                       CORE_CLK_I,
    input  wire logic                       RESETN_I,
    input  wire logic                       PSEL_I,
    input  wire logic                       PENABLE_I,
    input  wire logic                       PWRITE_I,
    input  wire logic [oagen_pkg::APB_AW-1:0] PADDR_I,
    input  wire logic [31:0]                PWDATA_I,
    output logic      [31:0]                PRDATA_O,
    output logic                            PREADY_O,
    output logic                            PSLVERR_O,
    input  wire logic                       REQ_VALID_I,
    input  wire oagen_pkg::oagen_class_e    REQ_CLASS_I,
    input  wire oagen_pkg::oagen_mode_e     REQ_MODE_I,
    input  wire logic                       REQ_DEST_I,
    input  wire logic                       REQ_LONG_LIT_I,
    input  wire logic [3:0]                 OP1_SEL_I,
    input  wire logic [3:0]                 PTR_SEL_I,
    input  wire logic [3:0]                 OFS_SEL_I,
    input  wire logic [15:0]                LIT_I,
    input  wire logic [15:0]                DELTA_I,
    input  wire logic [15:0]                FILE_ADDR_I,
    input  wire logic                       WB_VALID_I,
    input  wire logic [3:0]                 WB_SEL_I,
    input  wire logic [15:0]                WB_DATA_I,
    input  wire logic                       PF_VALID_I,
    input  wire logic [3:0]                 PF_X_SEL_I,
    input  wire logic [3:0]                 PF_Y_SEL_I,
    input  wire logic [15:0]                PF_X_DELTA_I,
    input  wire logic [15:0]                PF_Y_DELTA_I,
    output logic                            EA_VALID_O,
    output logic      [15:0]                EA_O,
    output logic                            EA_MEM_O,
    output logic                            EA_WRITE_O,
    output logic      [15:0]                OPERAND_O,
    output logic      [15:0]                OP1_O,
    output logic                            MODE_ERR_O,
    output logic                            PF_VALID_O,
    output logic      [15:0]                PF_X_ADDR_O,
    output logic      [15:0]                PF_Y_ADDR_O,
    output logic                            PF_ERR_O
);
    import oagen_pkg::*;

    // modulo step; length is implied by start and end, never stored
    function automatic logic [15:0] mod_step(input logic [15:0] p, input logic [15:0] d,
                                             input logic on, input logic [15:0] s,
                                             input logic [15:0] e);
        logic [15:0] sum;
        sum = p + d;
        mod_step = sum;
        if (on && (sum > e))
        begin
            mod_step = s;
        end
        else if (on && (sum < s))
        begin
            mod_step = e;
        end
    endfunction

    function automatic logic mode_legal(input oagen_class_e c, input oagen_mode_e m);
        mode_legal = 1'b1;
        if ((c == OAG_CLASS_MCU) && ((m == OAG_IND_REGOFS) || (m == OAG_IND_LITOFS)))
        begin
            mode_legal = 1'b0;
        end
    endfunction

    logic [15:0] default_working_register      [NUM_DEFAULT_WORKING_REGISTER];
    logic [15:0] next_default_working_register [NUM_DEFAULT_WORKING_REGISTER];
    logic [15:0] ctrl, next_ctrl;
    logic [15:0] xstart, next_xstart;
    logic [15:0] xend, next_xend;
    logic [15:0] ystart, next_ystart;
    logic [15:0] yend, next_yend;
    logic [31:0] prdata, next_prdata;
    logic        pready, next_pready;
    logic        pslverr, next_pslverr;
    logic        ea_valid, next_ea_valid;
    logic [15:0] ea, next_ea;
    logic        ea_mem, next_ea_mem;
    logic        ea_write, next_ea_write;
    logic [15:0] operand, next_operand;
    logic [15:0] op1, next_op1;
    logic        mode_err, next_mode_err;
    logic        pf_valid, next_pf_valid;
    logic [15:0] pf_x_addr, next_pf_x_addr;
    logic [15:0] pf_y_addr, next_pf_y_addr;
    logic        pf_err, next_pf_err;

    logic [15:0] ptr_val;
    logic [15:0] ofs_val;
    logic [15:0] op1_val;
    logic [15:0] plain_step;
    logic [15:0] step_val;
    logic [15:0] pf_x_val;
    logic [15:0] pf_y_val;
    logic        x_mod_on;
    logic        y_mod_on;
    logic        main_mod;
    logic        req_go;
    logic        pf_ok;
    logic        addr_hit;

    assign ptr_val    = default_working_register[PTR_SEL_I];
    assign ofs_val    = default_working_register[OFS_SEL_I];                                 // [RULE12] [RULE21]
    assign op1_val    = default_working_register[OP1_SEL_I];
    assign pf_x_val   = default_working_register[PF_X_SEL_I];
    assign pf_y_val   = default_working_register[PF_Y_SEL_I];
    assign plain_step = ptr_val + DELTA_I;
    assign x_mod_on   = ctrl[XEN_BIT] && (ctrl[XSEL_MSB:XSEL_LSB] != SEL_OFF); // [RULE17] [RULE18]
    assign y_mod_on   = ctrl[YEN_BIT] && (ctrl[YSEL_MSB:YSEL_LSB] != SEL_OFF); // [RULE19]
    assign main_mod   = x_mod_on && (PTR_SEL_I == ctrl[XSEL_MSB:XSEL_LSB]);
    assign step_val   = mod_step(ptr_val, DELTA_I, main_mod, xstart, xend); // [RULE15] [RULE16]
    assign req_go     = REQ_VALID_I && mode_legal(REQ_CLASS_I, REQ_MODE_I); // [RULE11]
    assign pf_ok      = ((PF_X_SEL_I == PF_X0) || (PF_X_SEL_I == PF_X1))
                     && ((PF_Y_SEL_I == PF_Y0) || (PF_Y_SEL_I == PF_Y1)); // [RULE13] [RULE14]
    assign addr_hit   = (PADDR_I == OFS_CTRL) || (PADDR_I == OFS_XSTART)
                     || (PADDR_I == OFS_XEND) || (PADDR_I == OFS_YSTART)
                     || (PADDR_I == OFS_YEND) || (PADDR_I == OFS_STATUS);

    // apb slave: read data and error are captured in setup, so pready is high in the
    // first access cycle and no wait states are added
    always_comb
    begin
        next_ctrl    = ctrl;
        next_xstart  = xstart;
        next_xend    = xend;
        next_ystart  = ystart;
        next_yend    = yend;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (PSEL_I && !PENABLE_I)
        begin
            next_pready  = 1'b1;
            next_pslverr = !addr_hit;
            case (PADDR_I)
                OFS_CTRL:   next_prdata = {16'h0000, ctrl};
                OFS_XSTART: next_prdata = {16'h0000, xstart};
                OFS_XEND:   next_prdata = {16'h0000, xend};
                OFS_YSTART: next_prdata = {16'h0000, ystart};
                OFS_YEND:   next_prdata = {16'h0000, yend};
                OFS_STATUS: next_prdata = {pf_x_addr, ea};
                default:    next_prdata = 32'h0000_0000;
            endcase
        end
        if (PSEL_I && PENABLE_I && pready && PWRITE_I)
        begin
            case (PADDR_I)
                OFS_CTRL:   next_ctrl   = PWDATA_I[15:0];
                OFS_XSTART: next_xstart = PWDATA_I[15:0];
                OFS_XEND:   next_xend   = PWDATA_I[15:0];
                OFS_YSTART: next_ystart = PWDATA_I[15:0];
                OFS_YEND:   next_yend   = PWDATA_I[15:0];
                default:    next_ctrl   = ctrl;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            ctrl    <= CTRL_RST;
            xstart  <= START_RST;
            xend    <= END_RST;
            ystart  <= START_RST;
            yend    <= END_RST;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl    <= next_ctrl;
            xstart  <= next_xstart;
            xend    <= next_xend;
            ystart  <= next_ystart;
            yend    <= next_yend;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // address generation; pointer updates are applied after the result writeback so a
    // same-cycle clash on one register leaves the pointer arithmetic in place
    always_comb
    begin
        next_default_working_register     = default_working_register;
        next_ea_valid = 1'b0;
        next_ea       = ea;
        next_ea_mem   = 1'b0;
        next_ea_write = 1'b0;
        next_operand  = operand;
        next_op1      = op1_val;                                         // [RULE1]
        next_mode_err = REQ_VALID_I && !req_go;                          // [RULE11]
        next_pf_valid = PF_VALID_I && pf_ok;
        next_pf_err   = PF_VALID_I && !pf_ok;                            // [RULE13]
        next_pf_x_addr = pf_x_addr;
        next_pf_y_addr = pf_y_addr;
        if (WB_VALID_I)
        begin
            next_default_working_register[WB_SEL_I] = WB_DATA_I;                             // [RULE2] [RULE5]
        end
        if (PF_VALID_I && pf_ok)
        begin
            next_pf_x_addr = pf_x_val;                                   // [RULE14]
            next_pf_y_addr = pf_y_val;
            next_default_working_register[PF_X_SEL_I] = mod_step(pf_x_val, PF_X_DELTA_I,
                x_mod_on && (PF_X_SEL_I == ctrl[XSEL_MSB:XSEL_LSB]), xstart, xend);
            next_default_working_register[PF_Y_SEL_I] = mod_step(pf_y_val, PF_Y_DELTA_I,
                y_mod_on && (PF_Y_SEL_I == ctrl[YSEL_MSB:YSEL_LSB]), ystart, yend);
        end
        if (req_go)
        begin
            next_ea_valid = 1'b1;
            next_ea_mem   = 1'b1;
            next_ea_write = REQ_DEST_I;                                  // [RULE2]
            case (REQ_MODE_I)
                OAG_FILE_DIRECT: next_ea = FILE_ADDR_I;                  // [RULE4]
                OAG_REG_DIRECT:
                begin
                    next_ea_mem  = 1'b0;                                 // [RULE5]
                    next_operand = ptr_val;
                end
                OAG_IND:        next_ea = ptr_val;                       // [RULE6]
                OAG_IND_POST:
                begin
                    next_ea              = ptr_val;                      // [RULE7]
                    next_default_working_register[PTR_SEL_I] = step_val;                     // [RULE20]
                end
                OAG_IND_PRE:
                begin
                    next_ea              = step_val;                     // [RULE8]
                    next_default_working_register[PTR_SEL_I] = step_val;
                end
                OAG_IND_REGOFS: next_ea = ptr_val + ofs_val;             // [RULE9]
                OAG_IND_LITOFS: next_ea = ptr_val + LIT_I;               // [RULE10]
                OAG_LITERAL:
                begin
                    next_ea_mem = 1'b0;
                    if (REQ_CLASS_I == OAG_CLASS_MCU)
                    begin
                        next_operand = LIT_I & (REQ_LONG_LIT_I ? LIT10_MASK : LIT5_MASK); // [RULE3]
                    end
                    else
                    begin
                        next_operand = LIT_I & (REQ_LONG_LIT_I ? LIT16_MASK : LIT8_MASK); // [RULE11]
                    end
                end
                default:        next_ea = ea;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            for (int i = 0; i < NUM_DEFAULT_WORKING_REGISTER; i++)
            begin
                default_working_register[i] <= 16'h0000;
            end
            ea_valid  <= 1'b0;
            ea        <= 16'h0000;
            ea_mem    <= 1'b0;
            ea_write  <= 1'b0;
            operand   <= 16'h0000;
            op1       <= 16'h0000;
            mode_err  <= 1'b0;
            pf_valid  <= 1'b0;
            pf_x_addr <= 16'h0000;
            pf_y_addr <= 16'h0000;
            pf_err    <= 1'b0;
        end
        else
        begin
            default_working_register      <= next_default_working_register;
            ea_valid  <= next_ea_valid;
            ea        <= next_ea;
            ea_mem    <= next_ea_mem;
            ea_write  <= next_ea_write;
            operand   <= next_operand;
            op1       <= next_op1;
            mode_err  <= next_mode_err;
            pf_valid  <= next_pf_valid;
            pf_x_addr <= next_pf_x_addr;
            pf_y_addr <= next_pf_y_addr;
            pf_err    <= next_pf_err;
        end
    end

    assign PRDATA_O    = prdata;
    assign PREADY_O    = pready;
    assign PSLVERR_O   = pslverr;
    assign EA_VALID_O  = ea_valid;
    assign EA_O        = ea;
    assign EA_MEM_O    = ea_mem;
    assign EA_WRITE_O  = ea_write;
    assign OPERAND_O   = operand;
    assign OP1_O       = op1;
    assign MODE_ERR_O  = mode_err;
    assign PF_VALID_O  = pf_valid;
    assign PF_X_ADDR_O = pf_x_addr;
    assign PF_Y_ADDR_O = pf_y_addr;
    assign PF_ERR_O    = pf_err;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    property p_op1_direct;
        REQ_VALID_I |=> (OP1_O == $past(op1_val));
    endproperty
    a_op1_direct: assert property (p_op1_direct) // [RULE1]
        else $error("first source not taken from working register");

    property p_reg_direct;
        req_go && (REQ_MODE_I == OAG_REG_DIRECT)
            |=> EA_VALID_O && !EA_MEM_O && (OPERAND_O == $past(ptr_val));
    endproperty
    a_reg_direct: assert property (p_reg_direct) // [RULE5]
        else $error("register direct made a memory access or wrong value");

    property p_file_direct;
        req_go && (REQ_MODE_I == OAG_FILE_DIRECT) |=> EA_MEM_O && (EA_O == $past(FILE_ADDR_I));
    endproperty
    a_file_direct: assert property (p_file_direct) // [RULE4]
        else $error("file direct address differs from field");

    property p_indirect;
        req_go && (REQ_MODE_I == OAG_IND) |=> (EA_O == $past(ptr_val));
    endproperty
    a_indirect: assert property (p_indirect) // [RULE6]
        else $error("indirect address is not the pointer");

    property p_post;
        req_go && (REQ_MODE_I == OAG_IND_POST) && !main_mod
            |=> (EA_O == $past(ptr_val)) && (default_working_register[$past(PTR_SEL_I)] == $past(plain_step));
    endproperty
    a_post: assert property (p_post) // [RULE7]
        else $error("post-modify address or pointer update wrong");

    property p_pre;
        req_go && (REQ_MODE_I == OAG_IND_PRE) && !main_mod |=> (EA_O == $past(plain_step));
    endproperty
    a_pre: assert property (p_pre) // [RULE8]
        else $error("pre-modify address is not the stepped pointer");

    property p_regofs;
        req_go && (REQ_MODE_I == OAG_IND_REGOFS)
            |=> (EA_O == 16'($past(ptr_val) + $past(ofs_val)));
    endproperty
    a_regofs: assert property (p_regofs) // [RULE9]
        else $error("register offset sum wrong");

    property p_litofs;
        req_go && (REQ_MODE_I == OAG_IND_LITOFS) |=> (EA_O == 16'($past(ptr_val) + $past(LIT_I)));
    endproperty
    a_litofs: assert property (p_litofs) // [RULE10]
        else $error("literal offset sum wrong");

    property p_mcu_no_idx;
        REQ_VALID_I && (REQ_CLASS_I == OAG_CLASS_MCU)
            && ((REQ_MODE_I == OAG_IND_REGOFS) || (REQ_MODE_I == OAG_IND_LITOFS))
            |=> MODE_ERR_O && !EA_VALID_O;
    endproperty
    a_mcu_no_idx: assert property (p_mcu_no_idx) // [RULE11]
        else $error("offset mode accepted for general instruction");

    property p_lit5;
        req_go && (REQ_CLASS_I == OAG_CLASS_MCU) && (REQ_MODE_I == OAG_LITERAL) && !REQ_LONG_LIT_I
            |=> (OPERAND_O == ($past(LIT_I) & LIT5_MASK));
    endproperty
    a_lit5: assert property (p_lit5) // [RULE3]
        else $error("short literal not cut to five bits");

    property p_pf_reject;
        PF_VALID_I && !pf_ok |=> PF_ERR_O && !PF_VALID_O;
    endproperty
    a_pf_reject: assert property (p_pf_reject) // [RULE13]
        else $error("illegal prefetch pointer accepted");

    property p_pf_route;
        PF_VALID_I && pf_ok
            |=> (PF_X_ADDR_O == $past(pf_x_val)) && (PF_Y_ADDR_O == $past(pf_y_val));
    endproperty
    a_pf_route: assert property (p_pf_route) // [RULE14]
        else $error("prefetch address routed to wrong generator");

    property p_wrap;
        req_go && (REQ_MODE_I == OAG_IND_POST) && main_mod && (plain_step > xend)
            && (plain_step >= xstart) |=> (default_working_register[$past(PTR_SEL_I)] == $past(xstart));
    endproperty
    a_wrap: assert property (p_wrap) // [RULE20]
        else $error("pointer past end did not wrap to start");

    property p_x_off;
        req_go && (REQ_MODE_I == OAG_IND_POST) && (ctrl[XSEL_MSB:XSEL_LSB] == SEL_OFF)
            |=> (default_working_register[$past(PTR_SEL_I)] == $past(plain_step));
    endproperty
    a_x_off: assert property (p_x_off) // [RULE17]
        else $error("modulo acted with X select disabled");
endmodule

// >>> oagen_dec_model.sv
// decoder-side model issuing address and prefetch requests
module oagen_dec_model (
    input  wire logic                   clk_i,
    output logic                        req_valid_o,
    output oagen_pkg::oagen_class_e     req_class_o,
    output oagen_pkg::oagen_mode_e      req_mode_o,
    output logic [3:0]                  ptr_sel_o,
    output logic [15:0]                 lit_o,
    output logic [15:0]                 delta_o,
    output logic                        pf_valid_o,
    output logic [3:0]                  pf_x_sel_o,
    output logic [3:0]                  pf_y_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import oagen_pkg::*;
    initial
    begin
        {req_valid_o, ptr_sel_o, lit_o, delta_o, pf_valid_o} = '0;
        {pf_x_sel_o, pf_y_sel_o} = '0;
        req_class_o = OAG_CLASS_MCU;
        req_mode_o = OAG_IND;
    end
    // a request stands for exactly one cycle, as the decoder issues one per instruction
    task automatic req(input oagen_class_e c, input oagen_mode_e m, input logic [3:0] p,
                       input logic [15:0] l, input logic [15:0] d);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_class_o <= c;
        req_mode_o  <= m;
        ptr_sel_o   <= p;
        lit_o       <= l;
        delta_o     <= d;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
    endtask
    // prefetch pointers only from 8..11 unless a test asks for a wrong one
    task automatic pf(input logic [3:0] x, input logic [3:0] y);
        @(posedge clk_i);
        {pf_valid_o, pf_x_sel_o, pf_y_sel_o} <= {1'b1, x, y};
        @(posedge clk_i);
        pf_valid_o <= 1'b0;
    endtask
endmodule

// >>> testbench.sv
// self-checking bench for the operand address generator
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import oagen_pkg::*;
    logic clk, rstn, psel, pen, pwr, wbv, rv, pv, perr, dst, ll, pfi;
    logic [7:0] pa;
    logic [31:0] pwd, prd;
    logic [3:0] op1, ofs, wbs, ps, px, py;
    logic [15:0] fa, wbd, lit, dl, pxd, pyd;
    logic ev, mem, wr, merr, pfv, pfe;
    logic [15:0] ea, opd, op1o, pfx, pfy;
    oagen_class_e cls;
    oagen_mode_e md;
    int n_fail, comparisons;
    logic [31:0] r;
    logic e;
    oagen_top i_dut (.CORE_CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rv),
        .PSLVERR_O(perr), .REQ_VALID_I(pv), .REQ_CLASS_I(cls), .REQ_MODE_I(md),
        .REQ_DEST_I(dst), .REQ_LONG_LIT_I(ll), .OP1_SEL_I(op1), .PTR_SEL_I(ps),
        .OFS_SEL_I(ofs), .LIT_I(lit), .DELTA_I(dl), .FILE_ADDR_I(fa), .WB_VALID_I(wbv),
        .WB_SEL_I(wbs), .WB_DATA_I(wbd), .PF_VALID_I(pfi),
        .PF_X_SEL_I(px), .PF_Y_SEL_I(py), .PF_X_DELTA_I(pxd), .PF_Y_DELTA_I(pyd),
        .EA_VALID_O(ev), .EA_O(ea), .EA_MEM_O(mem), .EA_WRITE_O(wr), .OPERAND_O(opd),
        .OP1_O(op1o), .MODE_ERR_O(merr), .PF_VALID_O(pfv), .PF_X_ADDR_O(pfx),
        .PF_Y_ADDR_O(pfy), .PF_ERR_O(pfe));
    oagen_dec_model i_dec (.clk_i(clk), .req_valid_o(pv), .req_class_o(cls),
        .req_mode_o(md), .ptr_sel_o(ps), .lit_o(lit), .delta_o(dl), .pf_valid_o(pfi),
        .pf_x_sel_o(px), .pf_y_sel_o(py));
    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        // read data and error are taken at the very edge that sees pready high
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (rv === 1'b1) break;
        end
        if (rv !== 1'b1) n_fail++;
        {r, e} = {prd, perr};
        {psel, pen} <= 2'b00;
    endtask
    task automatic rq(oagen_class_e c, oagen_mode_e m, logic [3:0] p, logic [15:0] l,
                      logic [15:0] d);
        i_dec.req(c, m, p, l, d);
        @(negedge clk);
    endtask
    task automatic wb(input logic [3:0] s, input logic [15:0] d);
        @(posedge clk);
        {wbv, wbs, wbd} <= {1'b1, s, d};
        @(posedge clk);
        wbv <= 1'b0;
    endtask
    task automatic pfc(logic [3:0] x, logic [3:0] y, logic [15:0] ex, logic [15:0] ey, logic er);
        i_dec.pf(x, y);
        @(negedge clk);
        chk({pfe, pfv}, {er, ~er});
        if (!er) chk({pfx, pfy}, {ex, ey});
    endtask
    task automatic summarize;
        $display("counts: %0d compared, %0d wrong", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        {psel, pen, pwr, pa, pwd, wbv, wbd, op1, ofs, fa, dst, pxd, pyd, ll, wbs} = '0;
        rstn = 0;
        repeat (12) @(posedge clk);
        rstn <= 1;
        apb(0, OFS_CTRL, 0); chk(r, {16'h0, CTRL_RST});
        apb(0, OFS_XEND, 0); chk(r, {16'h0, END_RST});
        apb(0, 8'h18, 0); chk(r, 32'h0); chk({31'h0, e}, 32'h1);
        $display("registers done");
        wb(3, 16'h1000); wb(4, 16'h0020); fa <= 16'h0abc;
        dst <= 1'b1;
        op1 <= 4'h4;
        rq(OAG_CLASS_MCU, OAG_FILE_DIRECT, 3, 0, 0);
        chk({ev, mem, wr, ea}, 19'h7_0abc);
        dst <= 1'b0;
        rq(OAG_CLASS_MCU, OAG_REG_DIRECT, 3, 0, 0); chk({mem, opd}, 17'h0_1000);
        chk(op1o, 16'h0020);
        rq(OAG_CLASS_MCU, OAG_IND_POST, 3, 0, 2); chk(ea, 16'h1000);
        rq(OAG_CLASS_MCU, OAG_IND, 3, 0, 0); chk(ea, 16'h1002);
        rq(OAG_CLASS_MCU, OAG_IND_PRE, 3, 0, 16'hfffe); chk(ea, 16'h1000);
        ofs <= 4;
        rq(OAG_CLASS_MCU, OAG_IND_REGOFS, 3, 0, 0); chk({merr, ev}, 2'b10);
        rq(OAG_CLASS_MOVE, OAG_IND_REGOFS, 3, 0, 0); chk(ea, 16'h1020);
        rq(OAG_CLASS_MOVE, OAG_IND_LITOFS, 3, 5, 0); chk(ea, 16'h1005);
        rq(OAG_CLASS_MCU, OAG_LITERAL, 3, 16'hffff, 0); chk(opd, 16'h001f);
        rq(OAG_CLASS_MOVE, OAG_LITERAL, 3, 16'hffff, 0); chk(opd, 16'h00ff);
        ll <= 1'b1;
        rq(OAG_CLASS_MCU, OAG_LITERAL, 3, 16'hffff, 0); chk(opd, 16'h03ff);
        rq(OAG_CLASS_MOVE, OAG_LITERAL, 3, 16'hffff, 0); chk(opd, 16'hffff);
        ll <= 1'b0;
        $display("modes done");
        apb(1, OFS_XSTART, 32'h1000); apb(1, OFS_XEND, 32'h1003); apb(1, OFS_CTRL, 32'h8003);
        wb(3, 16'h1002);
        rq(OAG_CLASS_MCU, OAG_IND_POST, 3, 0, 2); chk(ea, 16'h1002);
        rq(OAG_CLASS_MCU, OAG_IND_PRE, 3, 0, 0); chk(ea, 16'h1000);
        rq(OAG_CLASS_MCU, OAG_IND_PRE, 3, 0, 16'hfffe); chk(ea, 16'h1003);
        apb(1, OFS_CTRL, 32'h800f);
        rq(OAG_CLASS_MCU, OAG_IND_PRE, 3, 0, 1); chk(ea, 16'h1004);
        apb(1, OFS_CTRL, 32'h0003);
        rq(OAG_CLASS_MCU, OAG_IND_PRE, 3, 0, 1); chk(ea, 16'h1005);
        $display("modulo done");
        wb(8, 16'h2000); wb(10, 16'h3000); pxd <= 2; pyd <= 4;
        pfc(8, 10, 16'h2000, 16'h3000, 0);
        pfc(7, 10, 0, 0, 1);
        pfc(8, 9, 0, 0, 1);
        apb(1, OFS_YSTART, 32'h3000); apb(1, OFS_YEND, 32'h3005); apb(1, OFS_CTRL, 32'h40af);
        pfc(8, 10, 16'h2002, 16'h3004, 0);
        pfc(8, 10, 16'h2004, 16'h3000, 0);
        apb(0, OFS_STATUS, 0); chk(r, 32'h2004_1005);
        $display("prefetch done");
        summarize();
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule
